/* cbt_cfg.svh */
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CBT_CLK_NS          20
`define CBT_ABLANK_NS       300
`define CBT_ABLANK_CYC      ((`CBT_ABLANK_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)

// ****************************************************************
// Oscillator period counts
// ****************************************************************
`define CBT_CHOP_TICKS      16
`define CBT_FAST_TICKS      6
`define CBT_FORCE_TICKS     4
`define CBT_DEAD_TICKS      4
`define CBT_OC_MIN_TICKS    4
`define CBT_OC_MAX_TICKS    8
`define CBT_DBLANK_SHORT    4
`define CBT_DBLANK_LONG     8

`endif

/* cbt_pkg.sv */
package cbt_pkg;

    // ****************************************************************
    // Bridge state, Gray coded along off-charge-slow-fast
    // ****************************************************************
    typedef enum logic [1:0] {
        CBT_OFF    = 2'h0,
        CBT_CHARGE = 2'h1,
        CBT_SLOW   = 2'h3,
        CBT_FAST   = 2'h2
    } cbt_state_t;

    // Gate drive of one H-bridge
    typedef struct packed {
        logic u1;
        logic u2;
        logic l1;
        logic l2;
    } cbt_gate_t;

endpackage : cbt_pkg

/* cbt_chopper.sv */
`timescale 1ns/1ns
`include "cbt_cfg.svh"

// Summary of operation
// - Ignore overcurrent detector four oscillator periods
// - Shut outputs four to eight periods later
// - Stepping mode uses fixed analog blank
// - DC mode blank counts oscillator periods
// - Stepping mode forces digital blank zero
// - DC input transitions start digital blank
// - Charge phase start begins digital blank
// - DC start uses 37.5 percent mixed decay
// - DC mode: first four oscillator periods forced charge, blanked
// - Threshold at forced end goes fast
// - All timing but the analog blank (clock cycles) derived from reference oscillator
// - Overcurrent latches outputs off until reset or standby
// - Sequence charge slow fast, mirrored direction
module cbt_chopper
    import cbt_pkg::*;
#(
    parameter int CHOP_TICKS  = `CBT_CHOP_TICKS,
    parameter int FAST_TICKS  = `CBT_FAST_TICKS,
    parameter int ABLANK_CYC  = `CBT_ABLANK_CYC
) (
    // Clock and reset
    input  wire logic      MCLK,
    input  wire logic      RSTN,
    // Reference oscillator, one pulse per period
    input  wire logic      OSC_TICK,
    // Mode straps, caught after reset release
    input  wire logic      DC_MODE,
    input  wire logic      BLANK_LONG,
    // Controller inputs
    input  wire logic      STANDBY,
    input  wire logic      PHASE_IN,
    input  wire logic      PWM_IN,
    // Analog sense
    input  wire logic      CURRENT_TRIP,
    input  wire logic      OVERCURRENT_RAW,
    // Bridge and status
    output cbt_gate_t      BRIDGE,
    output cbt_state_t     DECAY_STATE,
    output logic           BLANK_ACTIVE,
    output logic           FAULT
);

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PW = $clog2(CHOP_TICKS);
    localparam int AW = $clog2(ABLANK_CYC + 1);
    localparam logic [PW-1:0] PER_LAST  = PW'(CHOP_TICKS - 1);
    localparam logic [PW-1:0] FAST_AT   = PW'(CHOP_TICKS - FAST_TICKS);
    localparam logic [PW-1:0] FORCE_END = PW'(`CBT_FORCE_TICKS);
    localparam logic [3:0]    DEAD_N    = 4'(`CBT_DEAD_TICKS);
    localparam logic [3:0]    OC_N      = 4'(`CBT_OC_MIN_TICKS);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic            init_q;      // Straps caught
    logic            dc_q;        // DC motor mode
    logic            blong_q;     // Long digital blank
    logic [PW-1:0]   per_q;       // Position in chop period
    cbt_state_t      state_q;     // Bridge state
    cbt_state_t      state_d;
    logic            phase_q;     // Previous direction input
    logic            pwm_q;       // Previous PWM input
    logic [3:0]      dbl_q;       // Digital blank periods left
    logic [3:0]      dbl_d;
    logic [AW-1:0]   abl_q;       // Analog blank cycles left
    logic [AW-1:0]   abl_d;
    logic [3:0]      dead_q;      // Overcurrent dead band left
    logic [3:0]      dead_d;
    logic [3:0]      oc_q;        // Persisting overcurrent periods
    logic [3:0]      oc_d;
    logic            fault_q;     // Latched shutdown
    cbt_gate_t       gate_q;      // Registered gate drive
    cbt_gate_t       gate_d;

    // ****************************************************************
    // Decode
    // ****************************************************************
    // All decode is combinational on registered state and the synchronous
    // pins. Blanking is a plain OR of the two blank counters, so a charge
    // start that lands inside a running digital blank simply extends it.
    // The comparator and the overcurrent detector are gated by the same
    // blank, which keeps recovery spikes from ending a charge or tripping.
    wire per_end    = OSC_TICK && (per_q == PER_LAST);
    wire in_edge    = (PHASE_IN != phase_q) || (PWM_IN != pwm_q);
    wire run        = init_q && !STANDBY && !fault_q;
    wire drive      = run && PWM_IN;
    wire forced     = dc_q && (per_q < FORCE_END);
    wire blank      = (dbl_q != 4'h0) || (abl_q != '0);
    wire trip_ok    = CURRENT_TRIP && !blank;
    wire oc_ok      = OVERCURRENT_RAW && !blank && (dead_q == 4'h0);
    wire chg_start  = (state_d == CBT_CHARGE) && (state_q != CBT_CHARGE);
    wire switching  = chg_start || (in_edge && init_q);
    wire [3:0] dbl_len = blong_q ? 4'(`CBT_DBLANK_LONG) : 4'(`CBT_DBLANK_SHORT);

    // ****************************************************************
    // Strap capture at reset release
    // ****************************************************************
    // Mode and blank length are chosen once, so a strap glitch later
    // cannot change blanking under a running motor.
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            init_q  <= 1'b0;
            dc_q    <= 1'b0;
            blong_q <= 1'b0;
        end else if (!init_q) begin
            init_q  <= 1'b1;
            dc_q    <= DC_MODE;
            blong_q <= BLANK_LONG;
        end
    end

    // ****************************************************************
    // Chop period counter
    // ****************************************************************
    // The counter only moves on oscillator pulses, so the chop frequency,
    // the digital blank and the dead band all follow the external RC.
    // It is not cleared by standby: the period keeps its phase, which
    // trades a fresh start for a counter with one clear source.
    // period from oscillator
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            per_q <= '0;
        end else if (per_end) begin
            per_q <= '0;
        end else if (OSC_TICK) begin
            per_q <= per_q + PW'(1);
        end
    end

    // ****************************************************************
    // Decay sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        if (!drive) begin
            // Brake or off
            state_d = run ? CBT_SLOW : CBT_OFF;
        end else if (!pwm_q) begin
            // brake to drive charges at once
            state_d = CBT_CHARGE;
        end else begin
            unique case (state_q)
                CBT_OFF: begin
                    state_d = CBT_CHARGE;
                end
                CBT_CHARGE: begin
                    if (forced) begin
                        state_d = CBT_CHARGE;
                    end else if (trip_ok && dc_q && per_q == FORCE_END) begin
                        state_d = CBT_FAST;
                    end else if (trip_ok) begin
                        state_d = (per_q >= FAST_AT) ? CBT_FAST : CBT_SLOW;
                    end
                end
                CBT_SLOW: begin
                    if (per_end) begin
                        state_d = CBT_CHARGE;
                    end else if (per_q >= FAST_AT) begin
                        state_d = CBT_FAST;
                    end
                end
                CBT_FAST: begin
                    if (per_end) begin
                        state_d = CBT_CHARGE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Gate pattern
    // ****************************************************************
    // Pattern is taken from the next state so the gates and the state
    // register move on the same edge. Slow decay shorts both low sides
    // and so needs no mirroring; charge and fast swap with direction.
    // mirrored by direction
    always_comb begin
        unique case (state_d)
            CBT_CHARGE: gate_d = PHASE_IN ? 4'h9 : 4'h6;
            CBT_SLOW:   gate_d = 4'h3;
            CBT_FAST:   gate_d = PHASE_IN ? 4'h6 : 4'h9;
            CBT_OFF:    gate_d = 4'h0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            state_q <= CBT_OFF;
            gate_q  <= '0;
            phase_q <= 1'b0;
            pwm_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            gate_q  <= gate_d;
            phase_q <= PHASE_IN;
            pwm_q   <= PWM_IN;
        end
    end

    // ****************************************************************
    // Blanking
    // ****************************************************************
    // Digital blank counts oscillator periods and exists in DC mode only;
    // the analog blank counts clock cycles and follows every charge start.
    // A new switching event restarts the digital count rather than adding
    // to it, so a fast PWM input can hold the comparator masked for good:
    // users must keep the PWM period longer than the chosen blank.
    always_comb begin
        dbl_d = dbl_q;
        abl_d = abl_q;
        if (!dc_q) begin
            dbl_d = 4'h0;
        end else if (switching) begin
            dbl_d = dbl_len;
        end else if (OSC_TICK && dbl_q != 4'h0) begin
            dbl_d = dbl_q - 4'h1;
        end
        if (chg_start) begin
            abl_d = AW'(ABLANK_CYC);
        end else if (abl_q != '0) begin
            abl_d = abl_q - AW'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            dbl_q <= 4'h0;
            abl_q <= '0;
        end else begin
            dbl_q <= dbl_d;
            abl_q <= abl_d;
        end
    end

    // ****************************************************************
    // Overcurrent detection
    // ****************************************************************
    // Persistence is counted in oscillator periods so a real short
    // stops the bridge four periods after it becomes visible; a dead
    // band may add up to four more.
    always_comb begin
        dead_d = dead_q;
        oc_d   = oc_q;
        if (switching || !run) begin
            dead_d = DEAD_N;
        end else if (OSC_TICK && dead_q != 4'h0) begin
            dead_d = dead_q - 4'h1;
        end
        if (!oc_ok) begin
            oc_d = 4'h0;
        end else if (OSC_TICK) begin
            oc_d = oc_q + 4'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            dead_q  <= DEAD_N;
            oc_q    <= 4'h0;
            fault_q <= 1'b0;
        end else begin
            dead_q <= dead_d;
            oc_q   <= oc_d;
            if (STANDBY) begin
                fault_q <= 1'b0;
            end else if (oc_d >= OC_N) begin
                fault_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The fault gate sits after the gate register so shutdown does not
    // wait for the sequencer; the state output is not gated and falls to CBT_OFF.
    // outputs forced off
    assign BRIDGE       = fault_q ? cbt_gate_t'(4'h0) : gate_q;
    assign DECAY_STATE  = state_q;
    assign BLANK_ACTIVE = blank;
    assign FAULT        = fault_q;

endmodule : cbt_chopper

/* cbt_chopper_note_unused.sv */
`timescale 1ns/1ns

/* cbt_ctrl_model.sv */
`timescale 1ns/1ns
// ****************************************
// Controller that drives direction and PWM
// ****************************************
module cbt_ctrl_model (
    // Clock
    input  wire logic mclk,
    // Levels asked for by the bench
    input  wire logic cmd_phase,
    input  wire logic cmd_pwm,
    // Pins toward the driver
    output logic      phase_pin,
    output logic      pwm_pin
);
    // Launched just after an edge and held, so the driver never sees a race
    initial begin
        phase_pin = 1'b0;
        pwm_pin   = 1'b0;
    end
    always @(posedge mclk) begin
        phase_pin <= cmd_phase;
        pwm_pin   <= cmd_pwm;
    end
endmodule : cbt_ctrl_model

/* cbt_chopper_assertions.sv */
`timescale 1ns/1ns
// ****************************************
// Port checker of the chopper
// ****************************************
module cbt_chopper_chk
    import cbt_pkg::*;
#(
    parameter int ABLANK_CYC = 15
) (
    // Clock and reset
    input wire logic       MCLK,
    input wire logic       RSTN,
    // Inputs
    input wire logic       OSC_TICK,
    input wire logic       DC_MODE,
    input wire logic       STANDBY,
    input wire logic       PHASE_IN,
    input wire logic       PWM_IN,
    input wire logic       OVERCURRENT_RAW,
    // Outputs
    input wire cbt_gate_t  BRIDGE,
    input wire cbt_state_t DECAY_STATE,
    input wire logic       BLANK_ACTIVE,
    input wire logic       FAULT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // Length of the current blank run
    logic [7:0] blen_q;
    // Gate pattern expected from state and direction
    cbt_gate_t  map_w;
    assign map_w = (DECAY_STATE == CBT_SLOW) ? 4'h3 : (DECAY_STATE == CBT_OFF) ? 4'h0 :
                   ((DECAY_STATE == CBT_CHARGE) == PHASE_IN) ? 4'h9 : 4'h6;
    // Cleared whenever the blank drops, so only one run is measured
    always_ff @(posedge MCLK) begin
        blen_q <= (!RSTN || !BLANK_ACTIVE) ? 8'h00 : blen_q + 8'h01;
    end
    AST_FAULT_CAUSE: assert property (
        $rose(FAULT) |-> $past(OSC_TICK) && $past(OVERCURRENT_RAW) &&
        !$past(BLANK_ACTIVE) && $past(OVERCURRENT_RAW, 7))
        else $error("fault without a lasting unmasked overcurrent");
    AST_FAULT_OFF: assert property (
        FAULT && $past(FAULT) |-> BRIDGE == 4'h0) else $error("bridge on in fault");
    AST_FAULT_HOLD: assert property (
        FAULT && !STANDBY |=> FAULT) else $error("fault dropped");
    AST_STBY_CLEAR: assert property (
        STANDBY |=> !FAULT && BRIDGE == 4'h0) else $error("standby not honoured");
    AST_DC_BLANK: assert property (
        DC_MODE && $changed(PWM_IN) && !STANDBY && !FAULT |-> ##[1:2] BLANK_ACTIVE)
        else $error("no blank after input change");
    AST_CHARGE_BLANK: assert property (
        DECAY_STATE == CBT_CHARGE && $past(DECAY_STATE) != CBT_CHARGE |-> BLANK_ACTIVE)
        else $error("charge start without blank");
    AST_ABLANK_LEN: assert property (
        !DC_MODE && $fell(BLANK_ACTIVE) |-> blen_q == ABLANK_CYC)
        else $error("analog blank length wrong");
    AST_BRIDGE_MAP: assert property (
        !FAULT && !STANDBY && !$past(FAULT) && !$past(STANDBY) && $stable(PHASE_IN)
        |-> BRIDGE == map_w) else $error("gate pattern wrong");
endmodule : cbt_chopper_chk

bind cbt_chopper cbt_chopper_chk #(.ABLANK_CYC(ABLANK_CYC)) u_chk (.MCLK(MCLK),
    .RSTN(RSTN), .OSC_TICK(OSC_TICK), .DC_MODE(DC_MODE), .STANDBY(STANDBY),
    .PHASE_IN(PHASE_IN), .PWM_IN(PWM_IN), .OVERCURRENT_RAW(OVERCURRENT_RAW),
    .BRIDGE(BRIDGE), .DECAY_STATE(DECAY_STATE), .BLANK_ACTIVE(BLANK_ACTIVE),
    .FAULT(FAULT));

/* test_chopper_blank_overcurrent_timing.sv */
`timescale 1ns/1ns
// ****************************************
// Bench of the chopper timing block
// ****************************************
module test_chopper_blank_overcurrent_timing;
    import cbt_pkg::*;
    logic       mclk = 1'b0, rstn = 1'b0, tick = 1'b0, dc = 1'b0, lng = 1'b0;
    logic       stby = 1'b0, ph = 1'b0, pwm = 1'b0, trip = 1'b0, oc = 1'b0;
    logic       ph_in, pwm_in, blank, fault;
    logic [1:0] div_q = 2'h0;
    cbt_gate_t  bridge;
    cbt_state_t state;
    int         error_cnt = 0, checked = 0, cyc = 0;
    cbt_ctrl_model ctrl (.mclk(mclk), .cmd_phase(ph), .cmd_pwm(pwm), .phase_pin(ph_in),
        .pwm_pin(pwm_in));
    cbt_chopper dut (.MCLK(mclk), .RSTN(rstn), .OSC_TICK(tick), .DC_MODE(dc),
        .BLANK_LONG(lng), .STANDBY(stby), .PHASE_IN(ph_in), .PWM_IN(pwm_in),
        .CURRENT_TRIP(trip), .OVERCURRENT_RAW(oc), .BRIDGE(bridge), .DECAY_STATE(state),
        .BLANK_ACTIVE(blank), .FAULT(fault));
    always #10 mclk = ~mclk;
    // Oscillator pulse every fourth clock; watchdog cuts a hang short
    always @(posedge mclk) begin
        div_q <= div_q + 2'h1;
        tick  <= (div_q == 2'h2);
        cyc   <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask : w
    task automatic drv(input logic p, input logic d, input logic t, input logic o);
        @(posedge mclk);
        pwm  <= p;
        ph   <= d;
        trip <= t;
        oc   <= o;
    endtask : drv
    // Reset with straps; checks the idle state after release
    task automatic start(input logic m, input logic l);
        drv(1'b0, 1'b0, 1'b0, 1'b0);
        rstn <= 1'b0;
        dc   <= m;
        lng  <= l;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        w(3);
        chk({fault, blank, state, bridge}, 8'h33); // cleared, brake idle
    endtask : start
    task automatic t_step();
        start(1'b0, 1'b0);
        drv(1'b1, 1'b0, 1'b1, 1'b0);
        w(3);
        chk({blank, state, bridge}, 8'h56); // reverse charge
        w(10);
        chk({blank, state}, 8'h05); // trip masked
        w(8);
        chk({blank, state == CBT_CHARGE}, 8'h00); // fixed blank over
        drv(1'b0, 1'b0, 1'b0, 1'b0);
        w(3);
        chk({blank, state, bridge}, 8'h33); // no digital blank
        drv(1'b1, 1'b1, 1'b0, 1'b0);
        w(3);
        chk({blank, state, bridge}, 8'h59); // forward charge
        $display("stepping test done");
    endtask : t_step
    task automatic t_dc(input logic l);
        int n;
        n = l ? 32 : 16;
        start(1'b1, l);
        drv(1'b1, 1'b1, 1'b1, 1'b0);
        w(3);
        chk({blank, state, bridge}, 8'h59); // forced charge
        w(n - 6);
        chk({blank, state}, 8'h05); // blank length
        w(14);
        chk({blank, state == CBT_CHARGE}, 8'h00); // blank ends
        drv(1'b0, 1'b1, 1'b1, 1'b0);
        w(3);
        chk({blank, state}, 8'h07); // brake change blanked
        $display("dc test done");
    endtask : t_dc
    // Trip held high in DC mode: fast tail, then charge straight to fast
    task automatic t_fast();
        int i;
        start(1'b1, 1'b0);
        drv(1'b1, 1'b1, 1'b1, 1'b0);
        for (i = 0; i < 80 && state !== CBT_FAST; i++) begin
            w(1);
        end
        chk(state, 8'h02); // fast tail reached
        for (i = 0; i < 80 && state !== CBT_CHARGE; i++) begin
            w(1);
        end
        for (i = 0; i < 80 && state === CBT_CHARGE; i++) begin
            w(1);
        end
        chk(state, 8'h02); // charge straight to fast
        $display("fast decay test done");
    endtask : t_fast
    // Switching event, then a lasting overcurrent until shutdown
    task automatic oc_hit();
        int i;
        drv(1'b1, 1'b1, 1'b0, 1'b0);
        w(4);
        drv(1'b0, 1'b1, 1'b0, 1'b1);
        w(13);
        chk(fault, 8'h00); // dead band
        for (i = 0; i < 23 && fault !== 1'b1; i++) begin
            w(1);
        end
        chk({fault, bridge}, 8'h10); // shutdown in time
    endtask : oc_hit
    task automatic t_oc();
        start(1'b1, 1'b0);
        oc_hit();
        drv(1'b0, 1'b1, 1'b0, 1'b0);
        w(20);
        chk(fault, 8'h01); // latched
        @(posedge mclk);
        stby <= 1'b1;
        w(2);
        chk({fault, bridge}, 8'h00); // standby clears
        @(posedge mclk);
        stby <= 1'b0;
        oc_hit();
        start(1'b0, 1'b0);
        $display("overcurrent test done");
    endtask : t_oc
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        t_step();
        t_dc(1'b0);
        t_dc(1'b1);
        t_fast();
        t_oc();
        give_verdict();
    end
endmodule : test_chopper_blank_overcurrent_timing
